/* logic/csba_top.sv */
`timescale 1ns/1ns
`include "csba_map.svh"
module csba_top
  import csba_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic three_wire,
  input wire logic breakpoint_instr_variant,
  input wire logic iack_req,
  input wire logic [2:0] iack_level,
  input wire logic breakpoint_instr,
  input wire logic mastership_request_n,
  input wire logic grant_acknowledge_n,
  input wire logic xfer_ack_n,
  input wire logic periph_valid_n,
  input wire logic bus_fault_n,
  input wire logic [7:0] data_in,
  output logic mastership_grant_n,
  output logic bus_release,
  output logic [2:0] func_code,
  output logic [23:1] addr_out,
  output logic addr_strobe_n,
  output logic upper_byte_strobe_n,
  output logic lower_byte_strobe_n,
  output logic read_not_write,
  output logic data_oe,
  output logic busy,
  output logic vector_valid,
  output logic [7:0] vector_out,
  output logic illegal_instr_trap,
  output logic fault_seen
);
  csba_arb_if hs ();
  csba_cyc_t cyc_reg;
  logic is_breakpoint_instr_reg;
  logic [2:0] lvl_reg;
  logic [3:0] cnt_reg;
  logic strobe_drive;

  // space-cycle address: type on A19-A16, level on A3-A1
  function automatic logic [23:1] csba_space_addr(input logic bk,
    input logic [2:0] lvl);
    logic [23:1] a;
    a = '1; // [R04]
    if (bk) begin
      a[19:16] = `CSBA_TYPE_BREAKPOINT_INSTR; // [R03] [R02]
    end else begin
      a[19:16] = `CSBA_TYPE_IACK; // [R02]
      a[3:1] = lvl; // [R04]
    end
    return a;
  endfunction

  csba_arbiter u_arb (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .three_wire(three_wire),
    .mastership_request_n(mastership_request_n),
    .grant_acknowledge_n(grant_acknowledge_n),
    .addr_strobe_n(addr_strobe_n),
    .mastership_grant_n(mastership_grant_n),
    .bus_release(bus_release),
    .hs(hs)
  );

  assign hs.cycle_commit = (cyc_reg == CSBA_CYC_COMMIT);
  assign hs.strobe_on = (cyc_reg == CSBA_CYC_STROBE);
  assign hs.cycle_busy = (cyc_reg != CSBA_CYC_IDLE);
  assign strobe_drive = (cyc_reg == CSBA_CYC_STROBE);
  assign busy = hs.cycle_busy;
  // reads only: space cycles never drive data [R09]
  assign data_oe = 1'b0;
  assign read_not_write = 1'b1;
  assign addr_strobe_n = ~strobe_drive;
  // both strobes even though vector is one byte [R08]
  assign upper_byte_strobe_n = ~strobe_drive;
  assign lower_byte_strobe_n = ~strobe_drive;

  // space-cycle sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cyc_reg <= CSBA_CYC_IDLE;
      is_breakpoint_instr_reg <= 1'b0;
      lvl_reg <= 3'h0;
      cnt_reg <= 4'h0;
    end else if (clk_en) begin
      unique case (cyc_reg)
        CSBA_CYC_IDLE: begin
          // only start while we own the bus
          if (hs.device_owns && !bus_release) begin
            if (breakpoint_instr_variant && breakpoint_instr) begin
              cyc_reg <= CSBA_CYC_COMMIT;
              is_breakpoint_instr_reg <= 1'b1; // [R09]
            end else if (iack_req) begin
              cyc_reg <= CSBA_CYC_COMMIT;
              is_breakpoint_instr_reg <= 1'b0;
              lvl_reg <= iack_level;
            end
          end
        end
        CSBA_CYC_COMMIT: begin
          cyc_reg <= CSBA_CYC_STROBE;
          cnt_reg <= 4'h0;
        end
        CSBA_CYC_STROBE: begin
          if (cnt_reg != `CSBA_CYCLE_CLKS) begin
            cnt_reg <= cnt_reg + 4'h1;
          end else if (!xfer_ack_n || !periph_valid_n || !bus_fault_n) begin
            cyc_reg <= CSBA_CYC_END; // [R10]
          end
        end
        CSBA_CYC_END: begin
          cyc_reg <= CSBA_CYC_IDLE;
        end
      endcase
    end
  end

  // address and function codes while a space cycle runs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      func_code <= 3'h0;
      addr_out <= '1;
    end else if (clk_en) begin
      if (cyc_reg == CSBA_CYC_IDLE) begin
        func_code <= 3'h0;
      end else begin
        func_code <= `CSBA_FC_SPACE; // [R01]
        addr_out <= csba_space_addr(is_breakpoint_instr_reg, lvl_reg);
      end
    end
  end

  // termination results: vector, autovector, trap
  always_ff @(posedge core_clk) begin
    if (rst) begin
      vector_valid <= 1'b0;
      vector_out <= 8'h00;
      illegal_instr_trap <= 1'b0;
      fault_seen <= 1'b0;
    end else if (clk_en) begin
      vector_valid <= 1'b0;
      illegal_instr_trap <= 1'b0;
      fault_seen <= 1'b0;
      if (cyc_reg == CSBA_CYC_STROBE && cnt_reg == `CSBA_CYCLE_CLKS) begin
        // fault wins; ack and autovector never together
        if (!bus_fault_n) begin
          fault_seen <= 1'b1;
          illegal_instr_trap <= is_breakpoint_instr_reg; // [R10]
        end else if (is_breakpoint_instr_reg) begin
          illegal_instr_trap <= !xfer_ack_n || !periph_valid_n; // [R10]
        end else if (!periph_valid_n) begin
          vector_valid <= 1'b1;
          vector_out <= `CSBA_AUTOVEC_BASE + {5'h00, lvl_reg}; // [R06]
        end else if (!xfer_ack_n) begin
          vector_valid <= 1'b1;
          vector_out <= data_in; // [R05] [R08]
        end
      end
    end
  end

  AST_FC_SPACE: assert property (@(posedge core_clk) disable iff (rst)
    !addr_strobe_n |-> func_code == `CSBA_FC_SPACE)
    else $error("fc not high"); // [R01]
  AST_AUTOVEC: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && hs.strobe_on && cnt_reg == `CSBA_CYCLE_CLKS && bus_fault_n
    && !periph_valid_n && !is_breakpoint_instr_reg) |=> vector_valid &&
    vector_out == 8'h18 + {5'h00, $past(lvl_reg)})
    else $error("bad autovector"); // [R06]
  AST_BREAKPOINT_INSTR_ADDR: assert property (@(posedge core_clk) disable iff (rst)
    (!addr_strobe_n && is_breakpoint_instr_reg) |-> addr_out[19:16] == 4'h0)
    else $error("breakpoint_instr type"); // [R03]
  AST_STROBES: assert property (@(posedge core_clk) disable iff (rst)
    !addr_strobe_n |-> !upper_byte_strobe_n && !lower_byte_strobe_n)
    else $error("strobes"); // [R08]
endmodule // csba_top

/* logic/csba_map.svh */
// Overview of operation
// [R01] - space cycle drives all function codes high
// [R02] - cycle type on A16-A19, sixteen types
// [R03] - breakpoint acknowledge puts A16-A19 all low
// [R04] - level on A3-A1, other address lines high
// [R05] - peripheral gives vector with transfer acknowledge
// [R06] - autovector input yields vector 0x18 plus level
// [R07] - never both acknowledge and autovector together
// [R08] - both strobes, vector from low byte only
// [R09] - breakpoint cycle read-like, no data moved
// [R10] - breakpoint ends on ack, fault, or valid
// [R11] - request, grant, acknowledge in that order
// [R12] - two-wire use holds acknowledge input high
// [R13] - requests may be wired-OR onto one input
// [R14] - three-wire grant drops after acknowledge seen
// [R15] - pending request re-grants a few clocks later
// [R16] - without acknowledge, grant held till bus idle
// [R17] - device yields only after current cycle ends
// [R18] - request withdrawn before ack is spurious
// [R19] - grant right after request is synchronized
// [R20] - committed cycle delays grant until strobe
// [R21] - grant may feed daisy chain or encoder
// [R22] - requester waits strobe, ack, prior grant-ack
// [R23] - acknowledge owner holds bus, drops request
// [R24] - arbitration inputs synchronized in two stages
// [R25] - arbiter outputs change on next clock edge
// [R26] - after reset grant negated, device owns bus
`ifndef CSBA_MAP_SVH
`define CSBA_MAP_SVH
`define CSBA_FC_SPACE 3'h7
`define CSBA_TYPE_IACK 4'hf
`define CSBA_TYPE_BREAKPOINT_INSTR 4'h0
`define CSBA_AUTOVEC_BASE 8'h18
`define CSBA_ADDR_W 24
`define CSBA_TYPE_LSB 16
`define CSBA_LEVEL_LSB 1
`define CSBA_CYCLE_CLKS 4'h4
`endif

/* logic/csba_pkg.sv */
package csba_pkg;
  typedef enum logic [1:0] {
    CSBA_ARB_OWN,
    CSBA_ARB_GRANT,
    CSBA_ARB_EXT,
    CSBA_ARB_REGRANT
  } csba_arb_t;
  typedef enum logic [1:0] {
    CSBA_CYC_IDLE,
    CSBA_CYC_COMMIT,
    CSBA_CYC_STROBE,
    CSBA_CYC_END
  } csba_cyc_t;
endpackage

/* logic/csba_arb_if.sv */
`timescale 1ns/1ns
// arbitration hand-off between cycle engine and arbiter
interface csba_arb_if;
  logic cycle_commit;
  logic strobe_on;
  logic cycle_busy;
  logic device_owns;
  modport cyc (output cycle_commit, output strobe_on, output cycle_busy,
    input device_owns);
  modport arb (input cycle_commit, input strobe_on, input cycle_busy,
    output device_owns);
endinterface

/* logic/csba_arbiter.sv */
`timescale 1ns/1ns
`include "csba_map.svh"
module csba_arbiter
  import csba_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic three_wire,
  input wire logic mastership_request_n,
  input wire logic grant_acknowledge_n,
  input wire logic addr_strobe_n,
  output logic mastership_grant_n,
  output logic bus_release,
  csba_arb_if.arb hs
);
  logic req_s1_reg, req_s2_reg, ack_s1_reg, ack_s2_reg;
  csba_arb_t state_reg;
  logic req_i, ack_i, ext_busy;

  // two-stage sync, first stage read only by second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else if (clk_en) begin
      req_s1_reg <= ~mastership_request_n; // [R24] [R13]
      req_s2_reg <= req_s1_reg;
      ack_s1_reg <= ~grant_acknowledge_n & three_wire; // [R12]
      ack_s2_reg <= ack_s1_reg;
    end
  end

  assign req_i = req_s2_reg;
  assign ack_i = ack_s2_reg;
  // two-wire: busy while addr_strobe_n, the device's own strobe, is low
  assign ext_busy = three_wire ? ack_i : ~addr_strobe_n;

  // arbitration state, outputs move on the next edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= CSBA_ARB_OWN; // [R26]
    end else if (clk_en) begin // [R25]
      unique case (state_reg)
        CSBA_ARB_OWN: begin
          // committed but no strobe yet: wait for the strobe [R20]
          if (req_i && !(hs.cycle_commit && !hs.strobe_on)) begin
            state_reg <= CSBA_ARB_GRANT; // [R19] [R11]
          end
        end
        CSBA_ARB_GRANT: begin
          if (three_wire && ack_i) begin
            state_reg <= CSBA_ARB_EXT; // [R14]
          end else if (!three_wire && !hs.cycle_busy && ext_busy) begin
            state_reg <= CSBA_ARB_EXT; // [R16]
          end else if (!req_i && !hs.cycle_busy) begin
            state_reg <= CSBA_ARB_OWN; // [R18]
          end
        end
        CSBA_ARB_EXT: begin
          if (three_wire && req_i) begin
            state_reg <= CSBA_ARB_REGRANT; // [R15]
          end else if (!ext_busy && !req_i) begin
            state_reg <= CSBA_ARB_OWN;
          end
        end
        CSBA_ARB_REGRANT: begin
          if (!ack_i && !req_i) begin
            state_reg <= CSBA_ARB_OWN;
          end else if (!ack_i) begin
            state_reg <= CSBA_ARB_GRANT; // [R15]
          end
        end
      endcase
    end
  end

  // grant low while granting; two-wire holds it through ext use [R16]
  assign mastership_grant_n = !(state_reg == CSBA_ARB_GRANT ||
    state_reg == CSBA_ARB_REGRANT ||
    (!three_wire && state_reg == CSBA_ARB_EXT));
  // release only once our own cycle has ended [R17]
  assign bus_release = (state_reg != CSBA_ARB_OWN) && !hs.cycle_busy;
  assign hs.device_owns = (state_reg == CSBA_ARB_OWN) ||
    (state_reg == CSBA_ARB_GRANT && !three_wire && !ext_busy) ||
    (state_reg == CSBA_ARB_GRANT && three_wire);

  AST_RESET_GRANT: assert property (@(posedge core_clk)
    rst |=> mastership_grant_n) else $error("grant after reset"); // [R26]
  AST_ACK_DROPS: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && three_wire && state_reg == CSBA_ARB_GRANT && ack_i)
    |=> !(state_reg == CSBA_ARB_GRANT)) else $error("grant held"); // [R14]
  AST_SPURIOUS: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && state_reg == CSBA_ARB_GRANT && !req_i && !ack_i &&
    !hs.cycle_busy && !ext_busy) |=> state_reg == CSBA_ARB_OWN)
    else $error("spurious not dropped"); // [R18]
  AST_HOLDOFF: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && state_reg == CSBA_ARB_OWN && hs.cycle_commit &&
    !hs.strobe_on) |=> mastership_grant_n) else $error("early"); // [R20]
  AST_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
    hs.cycle_busy |-> !bus_release) else $error("mid-cycle"); // [R17]
endmodule // csba_arbiter

/* test/csba_partner.sv */
`timescale 1ns/1ns
module csba_partner (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic three_wire,
  input wire logic addr_strobe_n,
  input wire logic mastership_grant_n,
  input wire logic [1:0] term_mode,
  input wire logic [1:0] term_wait,
  input wire logic [7:0] vec,
  input wire logic want_bus,
  input wire logic ack_en,
  output logic xfer_ack_n,
  output logic periph_valid_n,
  output logic bus_fault_n,
  output logic [7:0] data_in,
  output logic mastership_request_n,
  output logic grant_acknowledge_n
);
  logic [1:0] wait_reg;
  logic acked_reg;
  logic [3:0] hold_reg;
  // one termination per strobe, released with the strobe
  always_ff @(posedge core_clk) begin
    if (rst || addr_strobe_n) begin
      wait_reg <= 2'h0;
      xfer_ack_n <= 1'b1;
      periph_valid_n <= 1'b1;
      bus_fault_n <= 1'b1;
    end else if (wait_reg != term_wait) begin
      wait_reg <= wait_reg + 2'h1;
    end else begin
      xfer_ack_n <= term_mode != 2'h0;
      periph_valid_n <= term_mode != 2'h1;
      bus_fault_n <= term_mode != 2'h2;
    end
  end
  // released lane shows inverted data, never a stale vector
  assign data_in = xfer_ack_n ? ~vec : vec;
  // take the bus only once strobe and acknowledge are gone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      acked_reg <= 1'b0;
      hold_reg <= 4'h0;
    end else if (acked_reg) begin
      hold_reg <= hold_reg + 4'h1;
      acked_reg <= hold_reg != 4'hf;
    end else if (want_bus && ack_en && three_wire && !mastership_grant_n
        && addr_strobe_n && xfer_ack_n) begin
      acked_reg <= 1'b1;
    end
  end
  // two-wire use keeps the acknowledge line high
  assign grant_acknowledge_n = !(three_wire && acked_reg);
  assign mastership_request_n = !(want_bus && !acked_reg);
endmodule // csba_partner

/* test/tb.sv */
`timescale 1ns/1ns
module tb;
  logic core_clk = 0, rst = 1, three_wire = 1, breakpoint_instr_variant = 0;
  logic clk_en = 1;
  logic iack_req = 0, breakpoint_instr = 0, want_bus = 0, ack_en = 1;
  logic req2_n = 1, part_req_n, mastership_request_n, grant_acknowledge_n;
  logic [2:0] iack_level = 0, func_code, fc_s, p_s;
  logic [1:0] term_mode = 0, term_wait = 0;
  logic [7:0] vec = 0, data_in, vector_out, v_s;
  logic xfer_ack_n, periph_valid_n, bus_fault_n, mastership_grant_n;
  logic [23:1] addr_out, a_s;
  logic bus_release, addr_strobe_n, upper_byte_strobe_n, u_s, l_s, oe_s;
  logic lower_byte_strobe_n, read_not_write, data_oe, busy;
  logic vector_valid, illegal_instr_trap, fault_seen;
  int fails = 0, checks = 0;
  always #50 core_clk = ~core_clk;
  assign mastership_request_n = part_req_n & req2_n; // wired request
  csba_top csba_top_inst (.core_clk, .rst, .clk_en, .three_wire,
    .breakpoint_instr_variant, .iack_req, .iack_level, .breakpoint_instr,
    .mastership_request_n, .grant_acknowledge_n, .xfer_ack_n,
    .periph_valid_n, .bus_fault_n, .data_in, .mastership_grant_n,
    .bus_release, .func_code, .addr_out, .addr_strobe_n,
    .upper_byte_strobe_n, .lower_byte_strobe_n, .read_not_write, .data_oe,
    .busy, .vector_valid, .vector_out, .illegal_instr_trap, .fault_seen);
  csba_partner csba_partner_inst (.core_clk, .rst, .three_wire,
    .addr_strobe_n, .mastership_grant_n, .term_mode, .term_wait, .vec,
    .want_bus, .ack_en, .xfer_ack_n, .periph_valid_n, .bus_fault_n,
    .data_in, .mastership_request_n(part_req_n), .grant_acknowledge_n);
  task automatic check(input string n, input logic [23:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return mastership_grant_n;
      1: return grant_acknowledge_n;
      default: return bus_release;
    endcase
  endfunction
  // bounded wait on one handshake line, then judge it
  task automatic wait_for(input int w, input logic lvl, input int lim,
      input string n);
    int k;
    k = 0;
    while (pick(w) !== lvl && k < lim) begin
      @(negedge core_clk);
      k++;
    end
    check(n, pick(w), lvl);
  endtask
  // one space cycle; mid raises a bus request inside the strobe
  task automatic cyc(input logic bk, input logic [2:0] lv,
      input logic [1:0] m, input logic mid, input logic [7:0] v);
    int k;
    @(posedge core_clk);
    breakpoint_instr <= bk;
    iack_req <= !bk;
    iack_level <= lv;
    term_mode <= m;
    term_wait <= lv[1:0];
    vec <= v;
    @(posedge core_clk);
    breakpoint_instr <= 1'b0;
    iack_req <= 1'b0;
    k = 0;
    while (addr_strobe_n !== 1'b0 && k < 9) begin
      @(negedge core_clk);
      k++;
    end
    a_s = addr_out;
    fc_s = func_code;
    u_s = upper_byte_strobe_n;
    l_s = lower_byte_strobe_n;
    oe_s = data_oe | !read_not_write;
    if (mid) want_bus <= @(posedge core_clk) 1'b1;
    k = 0;
    p_s = 3'h0;
    while (p_s == 3'h0 && k < 20) begin
      @(negedge core_clk);
      p_s = {vector_valid, illegal_instr_trap, fault_seen};
      k++;
    end
    v_s = vector_out;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic t_iack;
    for (int m = 0; m < 2; m++) begin
      for (int i = 1; i < 8; i++) begin
        cyc(1'b0, 3'(i), 2'(m), 1'b0, 8'h40 + 8'(i));
        check("fc", fc_s, 3'h7);
        check("addr", a_s, {20'hfffff, 3'(i)});
        check("strobes", {u_s, l_s}, 2'h0);
        check("vec", v_s, m ? 8'h18 + 8'(i) : 8'h40 + 8'(i));
        check("pulse", p_s, 3'h4);
      end
    end
    $display("test iack done");
  endtask
  task automatic t_breakpoint_instr;
    breakpoint_instr_variant <= @(posedge core_clk) 1'b1;
    for (int m = 0; m < 3; m++) begin
      cyc(1'b1, 3'h0, 2'(m), 1'b0, 8'h5a);
      check("bk fc", fc_s, 3'h7);
      check("bk type", a_s[19:16], 4'h0);
      check("bk data", {oe_s, p_s[2]}, 2'h0);
      check("bk trap", p_s[1], 1'b1);
      check("bk fault", p_s[0], m == 2);
    end
    $display("test breakpoint_instr done");
  endtask
  task automatic t_arb3;
    cyc(1'b0, 3'h5, 2'h0, 1'b1, 8'h77);
    check("mid vec", v_s, 8'h77);
    wait_for(1, 1'b0, 10, "ack");
    wait_for(0, 1'b1, 6, "grant off");
    check("release", bus_release, 1'b1);
    want_bus <= @(posedge core_clk) 1'b0;
    wait_for(1, 1'b1, 20, "ack off");
    wait_for(2, 1'b0, 6, "own");
    $display("test arb3 done");
  endtask
  task automatic t_spur;
    @(posedge core_clk);
    ack_en <= 1'b0;
    want_bus <= 1'b1;
    wait_for(0, 1'b0, 5, "grant");
    @(posedge core_clk);
    want_bus <= 1'b0;
    wait_for(0, 1'b1, 6, "spurious");
    check("kept", bus_release, 1'b0);
    cyc(1'b0, 3'h2, 2'h1, 1'b0, 8'h00);
    check("after", p_s, 3'h4);
    ack_en <= @(posedge core_clk) 1'b1;
    $display("test spur done");
  endtask
  task automatic t_2wire;
    @(posedge core_clk);
    three_wire <= 1'b0;
    want_bus <= 1'b1;
    wait_for(0, 1'b0, 5, "grant2");
    repeat (20) @(negedge core_clk);
    check("held", {mastership_grant_n, bus_release}, 2'h1);
    check("no ack", grant_acknowledge_n, 1'b1);
    @(posedge core_clk);
    want_bus <= 1'b0;
    wait_for(0, 1'b1, 8, "drop2");
    three_wire <= @(posedge core_clk) 1'b1;
    $display("test 2wire done");
  endtask
  task automatic t_regrant;
    @(posedge core_clk);
    req2_n <= 1'b0;
    want_bus <= 1'b1;
    wait_for(1, 1'b0, 10, "ack r");
    wait_for(0, 1'b1, 6, "off r");
    wait_for(0, 1'b0, 8, "regrant");
    check("still held", grant_acknowledge_n, 1'b0);
    @(posedge core_clk);
    want_bus <= 1'b0;
    req2_n <= 1'b1;
    wait_for(1, 1'b1, 20, "ack off r");
    wait_for(0, 1'b1, 8, "idle");
    $display("test regrant done");
  endtask
  // request lands while committed: grant waits for the strobe,
  // then a frozen clock enable must stretch the running cycle
  task automatic t_hold;
    int k;
    @(posedge core_clk);
    ack_en <= 1'b0;
    want_bus <= 1'b1;
    term_mode <= 2'h1;
    term_wait <= 2'h0;
    iack_level <= 3'h3;
    @(posedge core_clk);
    iack_req <= 1'b1;
    @(posedge core_clk);
    iack_req <= 1'b0;
    repeat (2) @(negedge core_clk);
    check("held off", {mastership_grant_n, addr_strobe_n, busy}, 3'h5);
    @(posedge core_clk);
    want_bus <= 1'b0;
    clk_en <= 1'b0;
    @(negedge core_clk);
    check("granted", {mastership_grant_n, addr_strobe_n, busy}, 3'h1);
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    @(negedge core_clk);
    check("frozen", addr_strobe_n, 1'b0);
    k = 0;
    while (vector_valid !== 1'b1 && k < 12) begin
      @(negedge core_clk);
      k++;
    end
    check("hold vec", vector_out, 8'h1b);
    wait_for(0, 1'b1, 8, "hold end");
    $display("test hold done");
  endtask
  // the device must never yield while its own strobe is out
  always @(negedge core_clk)
    if (!rst && addr_strobe_n === 1'b0)
      check("yield", bus_release, 1'b0);
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    check("rst", {mastership_grant_n, addr_strobe_n, bus_release, func_code,
      busy}, 7'h60);
    t_iack();
    t_breakpoint_instr();
    t_arb3();
    t_spur();
    t_2wire();
    t_regrant();
    t_hold();
    summarize();
  end
  // watchdog: whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge core_clk);
    fails++;
    summarize();
  end
endmodule // tb
